//--- hw/sdsw_consts.vh
// Purpose: Constants for the servo drive status word block.
// Assumes: 25 MHz system clock, 32-bit register port.
// Notes: Byte offsets are word aligned; bit positions index the status word.
`ifndef SDSW_CONSTS_VH
`define SDSW_CONSTS_VH

// ---------------------------------------------------------------
// Clock and servo update timing
// ---------------------------------------------------------------
`define SDSW_CLK_MHZ 25
`define SDSW_UPDATE_US 250
`define SDSW_UPDATE_CYCLES (`SDSW_UPDATE_US * `SDSW_CLK_MHZ)

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SDSW_ADDR_W 8
`define SDSW_OFS_STATUS 8'h00
`define SDSW_OFS_VEL_WINDOW 8'h04
`define SDSW_OFS_STILL_WINDOW 8'h08
`define SDSW_OFS_VEL_THRESH 8'h0C
`define SDSW_OFS_TORQUE_LIMIT 8'h10
`define SDSW_OFS_VEL_LIMIT 8'h14
`define SDSW_OFS_LOCK_TOL 8'h18
`define SDSW_OFS_POWER_THRESH 8'h1C
`define SDSW_OFS_LOW_VEL_THRESH 8'h20
`define SDSW_OFS_HIGH_VEL_THRESH 8'h24

// ---------------------------------------------------------------
// Configuration reset values
// ---------------------------------------------------------------
`define SDSW_RST_CFG 32'h00000000
`define SDSW_RST_STATUS 32'h00000000

// ---------------------------------------------------------------
// Status word bit positions
// ---------------------------------------------------------------
`define SDSW_BIT_SERVO_ACT 0
`define SDSW_BIT_POWER_ACT 1
`define SDSW_BIT_SHUTDOWN 2
`define SDSW_BIT_TUNING 3
`define SDSW_BIT_HOME_IN 6
`define SDSW_BIT_CAPT1_IN 7
`define SDSW_BIT_CAPT2_IN 8
`define SDSW_BIT_POS_TRAVEL 9
`define SDSW_BIT_NEG_TRAVEL 10
`define SDSW_BIT_ENABLE_IN 11
`define SDSW_BIT_ACCEL_LIM 12
`define SDSW_BIT_ABS_HOMED 13
`define SDSW_BIT_VEL_LOCK 16
`define SDSW_BIT_ZERO_SPEED 17
`define SDSW_BIT_BELOW_LEVEL 18
`define SDSW_BIT_TORQUE_LIM 19
`define SDSW_BIT_SPEED_LIM 21
`define SDSW_BIT_POS_LOCK 22
`define SDSW_BIT_POWER_LIM 23
`define SDSW_BIT_LOW_LEVEL 25
`define SDSW_BIT_HIGH_LEVEL 26

`endif

//--- hw/sdsw_status.v
// Purpose: Builds the 32-bit drive status word of one servo axis and serves it with its
//          comparison limits over a simple register port.
// Assumes: All inputs synchronous to clk_sys; quantities are signed two's complement.
// Notes: Comparator and state bits refresh on the servo update tick; input mirrors
//        follow their pins every clock.
`include "sdsw_consts.vh"

// Functional notes
// RULE1: Bit 0 shows servo loops enabled.
// RULE2: Bit 1 shows power stage active.
// RULE3: Bit 2 shows axis in shutdown.
// RULE4: Bit 3 shows tuning or hookup test.
// RULE5: Bit 6 mirrors home input level.
// RULE6: Bits 7, 8 mirror capture inputs.
// RULE7: Bit 9 mirrors positive travel limit.
// RULE8: Bit 10 mirrors negative travel limit.
// RULE9: Bit 11 mirrors enable input.
// RULE10: Bit 12 acceleration command exceeds limit.
// RULE11: Bit 13 set on absolute home done.
// RULE12: Bit 13 cleared by defaults or home.
// RULE13: Bit 16 velocity error within window.
// RULE14: Bit 17 feedback within standstill window.
// RULE15: Bit 18 feedback below velocity threshold.
// RULE16: Torque flag when command exceeds limit.
// RULE17: Bit 21 velocity command exceeds limit.
// RULE18: Bit 22 position error within tolerance.
// RULE19: Power flag when power exceeds threshold.
// RULE20: Reserved bits always read zero.
// RULE21: Update per servo tick; reset clears. Bit 13 and mirror bits 11:6 update every clock; reset leaves bits 11:6 live.
module sdsw_status #(
   parameter UPDATE_CYCLES = `SDSW_UPDATE_CYCLES
) (
   input wire clk_sys,
   input wire sys_rst,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire servo_active,
   input wire power_active,
   input wire shutdown_state,
   input wire tuning_test_active,
   input wire homing_switch_level,
   input wire capture_one_level,
   input wire capture_two_level,
   input wire pos_travel_limit_level,
   input wire neg_travel_limit_level,
   input wire enable_input_level,
   input wire abs_home_done,
   input wire config_defaults,
   input wire home_performed,
   input wire [31:0] vel_feedback,
   input wire [31:0] vel_command,
   input wire [31:0] accel_command,
   input wire [31:0] torque_command,
   input wire [31:0] pos_error,
   input wire [31:0] supplied_power,
   output reg [31:0] axis_state_word,
   output reg update_tick
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Magnitude of a signed word; the most negative value maps to 2^31, which still fits.
   function [31:0] mag;
      input [31:0] v;
      begin
         mag = v[31] ? (~v + 32'h00000001) : v;
      end
   endfunction

   // ---------------------------------------------------------------
   // Servo update interval divider
   // ---------------------------------------------------------------
   reg [31:0] tick_count;

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         tick_count <= 32'h00000000;
         update_tick <= 1'b0;
      end else if (tick_count >= UPDATE_CYCLES - 1) begin
         tick_count <= 32'h00000000;
         update_tick <= 1'b1; // [RULE21]
      end else begin
         tick_count <= tick_count + 32'h00000001;
         update_tick <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   reg [31:0] vel_window;
   reg [31:0] still_window;
   reg [31:0] vel_thresh;
   reg [31:0] torque_limit;
   reg [31:0] vel_limit;
   reg [31:0] lock_tol;
   reg [31:0] power_thresh;
   reg [31:0] low_vel_thresh;
   reg [31:0] high_vel_thresh;

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         vel_window <= `SDSW_RST_CFG;
         still_window <= `SDSW_RST_CFG;
         vel_thresh <= `SDSW_RST_CFG;
         torque_limit <= `SDSW_RST_CFG;
         vel_limit <= `SDSW_RST_CFG;
         lock_tol <= `SDSW_RST_CFG;
         power_thresh <= `SDSW_RST_CFG;
         low_vel_thresh <= `SDSW_RST_CFG;
         high_vel_thresh <= `SDSW_RST_CFG;
      end else if (reg_wr) begin
         case (reg_addr)
            `SDSW_OFS_VEL_WINDOW: vel_window <= reg_wdata;
            `SDSW_OFS_STILL_WINDOW: still_window <= reg_wdata;
            `SDSW_OFS_VEL_THRESH: vel_thresh <= reg_wdata;
            `SDSW_OFS_TORQUE_LIMIT: torque_limit <= reg_wdata;
            `SDSW_OFS_VEL_LIMIT: vel_limit <= reg_wdata;
            `SDSW_OFS_LOCK_TOL: lock_tol <= reg_wdata;
            `SDSW_OFS_POWER_THRESH: power_thresh <= reg_wdata;
            `SDSW_OFS_LOW_VEL_THRESH: low_vel_thresh <= reg_wdata;
            `SDSW_OFS_HIGH_VEL_THRESH: high_vel_thresh <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Comparators
   // ---------------------------------------------------------------
   wire [32:0] vel_err;
   wire [32:0] vel_err_mag;
   wire [31:0] fb_mag;

   // The error is taken one bit wider so that opposite full-scale values cannot wrap.
   assign vel_err = {vel_feedback[31], vel_feedback} - {vel_command[31], vel_command};
   assign vel_err_mag = vel_err[32] ? (~vel_err + 33'h000000001) : vel_err;
   assign fb_mag = mag(vel_feedback);

   wire cmp_vel_lock = vel_err_mag <= {1'b0, vel_window}; // [RULE13]
   wire cmp_zero_speed = fb_mag <= still_window; // [RULE14]
   wire cmp_below_level = fb_mag < vel_thresh; // [RULE15]
   wire cmp_torque = mag(torque_command) > torque_limit; // [RULE16]
   wire cmp_speed_lim = mag(vel_command) > vel_limit; // [RULE17]
   // Acceleration is compared against the velocity limit setting, as the axis defines it.
   wire cmp_accel = mag(accel_command) > vel_limit; // [RULE10]
   wire cmp_pos_lock = mag(pos_error) <= lock_tol; // [RULE18]
   wire cmp_power = mag(supplied_power) > power_thresh; // [RULE19]
   wire cmp_low_level = fb_mag < low_vel_thresh;
   wire cmp_high_level = fb_mag > high_vel_thresh;

   // ---------------------------------------------------------------
   // Absolute reference flag
   // ---------------------------------------------------------------
   // Tracked every clock so that a completion or clear event between ticks is not lost;
   // a completion arriving with a clearing event wins.
   reg abs_homed_flag;

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         abs_homed_flag <= 1'b0;
      end else if (abs_home_done) begin
         abs_homed_flag <= 1'b1; // [RULE11]
      end else if (config_defaults || home_performed) begin
         abs_homed_flag <= 1'b0; // [RULE12]
      end
   end

   // ---------------------------------------------------------------
   // Status word assembly
   // ---------------------------------------------------------------
   reg [31:0] next_word;

   always @* begin
      next_word = axis_state_word;
      if (update_tick) begin
         next_word[`SDSW_BIT_SERVO_ACT] = servo_active; // [RULE1]
         next_word[`SDSW_BIT_POWER_ACT] = power_active; // [RULE2]
         next_word[`SDSW_BIT_SHUTDOWN] = shutdown_state; // [RULE3]
         next_word[`SDSW_BIT_TUNING] = tuning_test_active; // [RULE4]
         next_word[`SDSW_BIT_ACCEL_LIM] = cmp_accel; // [RULE10]
         next_word[`SDSW_BIT_VEL_LOCK] = cmp_vel_lock; // [RULE13]
         next_word[`SDSW_BIT_ZERO_SPEED] = cmp_zero_speed; // [RULE14]
         next_word[`SDSW_BIT_BELOW_LEVEL] = cmp_below_level; // [RULE15]
         next_word[`SDSW_BIT_TORQUE_LIM] = cmp_torque; // [RULE16]
         next_word[`SDSW_BIT_SPEED_LIM] = cmp_speed_lim; // [RULE17]
         next_word[`SDSW_BIT_POS_LOCK] = cmp_pos_lock; // [RULE18]
         next_word[`SDSW_BIT_POWER_LIM] = cmp_power; // [RULE19]
         next_word[`SDSW_BIT_LOW_LEVEL] = cmp_low_level;
         next_word[`SDSW_BIT_HIGH_LEVEL] = cmp_high_level;
      end
      next_word[`SDSW_BIT_ABS_HOMED] = abs_homed_flag; // [RULE11]
      // Pin mirrors follow every clock; they carry live levels and are not held by reset.
      next_word[`SDSW_BIT_HOME_IN] = homing_switch_level; // [RULE5]
      next_word[`SDSW_BIT_CAPT1_IN] = capture_one_level; // [RULE6]
      next_word[`SDSW_BIT_CAPT2_IN] = capture_two_level; // [RULE6]
      next_word[`SDSW_BIT_POS_TRAVEL] = pos_travel_limit_level; // [RULE7]
      next_word[`SDSW_BIT_NEG_TRAVEL] = neg_travel_limit_level; // [RULE8]
      next_word[`SDSW_BIT_ENABLE_IN] = enable_input_level; // [RULE9]
      next_word[5:4] = 2'h0; // [RULE20]
      next_word[15:14] = 2'h0; // [RULE20]
      next_word[20] = 1'b0; // [RULE20]
      next_word[24] = 1'b0; // [RULE20]
      next_word[31:27] = 5'h00; // [RULE20]
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         axis_state_word[5:0] <= 6'h00; // [RULE21]
         axis_state_word[31:12] <= 20'h00000; // [RULE21]
      end else begin
         axis_state_word[5:0] <= next_word[5:0];
         axis_state_word[31:12] <= next_word[31:12];
      end
      axis_state_word[11:6] <= next_word[11:6];
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst || !reg_rd) begin
         reg_rdata <= 32'h00000000;
      end else begin
         case (reg_addr)
            `SDSW_OFS_STATUS: reg_rdata <= axis_state_word;
            `SDSW_OFS_VEL_WINDOW: reg_rdata <= vel_window;
            `SDSW_OFS_STILL_WINDOW: reg_rdata <= still_window;
            `SDSW_OFS_VEL_THRESH: reg_rdata <= vel_thresh;
            `SDSW_OFS_TORQUE_LIMIT: reg_rdata <= torque_limit;
            `SDSW_OFS_VEL_LIMIT: reg_rdata <= vel_limit;
            `SDSW_OFS_LOCK_TOL: reg_rdata <= lock_tol;
            `SDSW_OFS_POWER_THRESH: reg_rdata <= power_thresh;
            `SDSW_OFS_LOW_VEL_THRESH: reg_rdata <= low_vel_thresh;
            `SDSW_OFS_HIGH_VEL_THRESH: reg_rdata <= high_vel_thresh;
            default: reg_rdata <= 32'h00000000;
         endcase
      end
   end

endmodule // sdsw_status

//--- verification/sdsw_status_assertions.sv
// Purpose: Port-level assertions for the servo drive status word block.
// Assumes: Bound to sdsw_status; one clock, synchronous active-high reset.
// Notes: Comparator results depend on limit registers, so the bench judges them.
module sdsw_status_assertions #(
   parameter UPDATE_CYCLES = 8
) (
   input wire clk_sys,
   input wire sys_rst,
   input wire [7:0] reg_addr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire servo_active,
   input wire power_active,
   input wire shutdown_state,
   input wire tuning_test_active,
   input wire homing_switch_level,
   input wire capture_one_level,
   input wire capture_two_level,
   input wire pos_travel_limit_level,
   input wire neg_travel_limit_level,
   input wire enable_input_level,
   input wire abs_home_done,
   input wire config_defaults,
   input wire home_performed,
   input wire [31:0] axis_state_word,
   input wire update_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [31:0] cnt;
   reg seen;
   // The period is only judged after the first tick, whose offset from reset is a design choice.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt <= 32'h00000000;
         seen <= 1'b0;
      end else begin
         cnt <= update_tick ? 32'h00000001 : cnt + 32'h00000001;
         seen <= seen | update_tick;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_mirror;
      1'b1 |=> axis_state_word[11:6] == $past({enable_input_level, neg_travel_limit_level,
         pos_travel_limit_level, capture_two_level, capture_one_level, homing_switch_level});
   endproperty
   a_mirror: assert property (p_mirror) else $error("input mirror bits wrong");
   property p_load;
      update_tick |=> axis_state_word[3:0] == $past({tuning_test_active, shutdown_state, power_active, servo_active});
   endproperty
   a_load: assert property (p_load) else $error("state bits not loaded on tick");
   property p_hold;
      !update_tick |=> $stable(axis_state_word[3:0]);
   endproperty
   a_hold: assert property (p_hold) else $error("state bits moved between ticks");
   property p_period;
      seen |-> (update_tick == (cnt == UPDATE_CYCLES));
   endproperty
   a_period: assert property (p_period) else $error("update tick period wrong");
   property p_abs_set;
      abs_home_done |-> ##2 axis_state_word[13];
   endproperty
   a_abs_set: assert property (p_abs_set) else $error("absolute flag not set");
   property p_abs_clr;
      (config_defaults || home_performed) && !abs_home_done |-> ##2 !axis_state_word[13];
   endproperty
   a_abs_clr: assert property (p_abs_clr) else $error("absolute flag not cleared");
   property p_abs_keep;
      !abs_home_done && !config_defaults && !home_performed |=> ##1 $stable(axis_state_word[13]);
   endproperty
   a_abs_keep: assert property (p_abs_keep) else $error("absolute flag changed alone");
   property p_reserved;
      (axis_state_word & 32'hF910C030) == 32'h00000000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");
   property p_read;
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(axis_state_word);
   endproperty
   a_read: assert property (p_read) else $error("status read data wrong");
   property p_reset;
      disable iff (1'b0) sys_rst |=> (axis_state_word & 32'hFFFFF03F) == 32'h00000000 && !update_tick;
   endproperty
   a_reset: assert property (p_reset) else $error("reset left bits set");
   c_tick: cover property (update_tick ##1 axis_state_word[0]);
   // The flag register and the word register each add one stage, so bit 13 lags its event by two edges.
   c_abs: cover property (abs_home_done ##2 axis_state_word[13]);
   c_read: cover property (reg_rd && reg_addr == 8'h00);
endmodule // sdsw_status_assertions

bind sdsw_status sdsw_status_assertions #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .servo_active(servo_active),
   .power_active(power_active), .shutdown_state(shutdown_state), .tuning_test_active(tuning_test_active),
   .homing_switch_level(homing_switch_level), .capture_one_level(capture_one_level),
   .capture_two_level(capture_two_level), .pos_travel_limit_level(pos_travel_limit_level),
   .neg_travel_limit_level(neg_travel_limit_level), .enable_input_level(enable_input_level),
   .abs_home_done(abs_home_done), .config_defaults(config_defaults), .home_performed(home_performed),
   .axis_state_word(axis_state_word), .update_tick(update_tick));

//--- verification/sdsw_status_tb_top.sv
// Purpose: Self-checking bench for the servo drive status word block.
// Assumes: Update interval shortened to 8 clocks.
// Notes: Comparator rows hit the window and limit boundaries on both signs.
`include "sdsw_consts.vh"
module sdsw_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int UPD = 8;
   localparam logic [31:0] CFG [9] = '{32'h64, 32'h32, 32'hC8, 32'h12C, 32'h3E8, 32'hA, 32'h1F4, 32'h14, 32'h7D0};
   // Columns: state nibble, feedback, command, accel, torque, position error, power, expected bits.
   localparam logic [31:0] ROWS [4][8] = '{
      '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h02470000},
      '{32'hF, 32'hFFFFFFCE, 32'h32, 32'h3E9, 32'h12D, 32'hFFFFFFF6, 32'h1F5, 32'h00CF100F},
      '{32'h5, 32'h7D1, 32'hFFFFFC17, 32'hFFFFFC18, 32'h12C, 32'hB, 32'h1F4, 32'h04200005},
      '{32'hA, 32'hC8, 32'h80000000, 32'h80000000, 32'hFFFFFED3, 32'h80000000, 32'hFFFFFE0B, 32'h00A8100A}};
   localparam logic [3:0] AB [5] = '{4'h9, 4'h2, 4'h9, 4'h4, 4'hD};
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] st = 4'h0;
   logic [5:0] mir = 6'h00;
   logic [2:0] abs = 3'h0;
   logic [31:0] q [6] = '{default: 32'h00000000};
   logic [31:0] rd;
   wire [31:0] reg_rdata;
   wire [31:0] axis_state_word;
   wire update_tick;
   int errors = 0;
   int checks = 0;
   always #20 clk_sys = ~clk_sys;
   sdsw_status #(.UPDATE_CYCLES(UPD)) u_sdsw_status (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .servo_active(st[0]),
      .power_active(st[1]), .shutdown_state(st[2]), .tuning_test_active(st[3]), .homing_switch_level(mir[0]),
      .capture_one_level(mir[1]), .capture_two_level(mir[2]), .pos_travel_limit_level(mir[3]),
      .neg_travel_limit_level(mir[4]), .enable_input_level(mir[5]), .abs_home_done(abs[0]),
      .config_defaults(abs[1]), .home_performed(abs[2]), .vel_feedback(q[0]), .vel_command(q[1]),
      .accel_command(q[2]), .torque_command(q[3]), .pos_error(q[4]), .supplied_power(q[5]),
      .axis_state_word(axis_state_word), .update_tick(update_tick));
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rdt(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      rd = reg_rdata;
   endtask
   task test_done;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Waits for a tick, then one more edge so the loaded bits are visible.
   task tick;
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (update_tick !== 1'b1 && n < 40);
      if (n >= 40) errors++;
      @(negedge clk_sys);
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rdt(8'h04 + 8'(4 * i));
         chk("config reset", rd, 32'h00000000);
         wr(8'h04 + 8'(4 * i), CFG[i]);
         rdt(8'h04 + 8'(4 * i));
         chk("config readback", rd, CFG[i]);
      end
      rdt(8'h40);
      chk("unmapped read", rd, 32'h00000000);
      @(negedge clk_sys);
      chk("read data idle", reg_rdata, 32'h00000000);
      $display("test registers done");
      for (int r = 0; r < 4; r++) begin
         @(posedge clk_sys);
         st <= ROWS[r][0][3:0];
         for (int j = 0; j < 6; j++) q[j] <= ROWS[r][j + 1];
         tick();
         chk("status bits", axis_state_word & 32'hFFFFD03F, ROWS[r][7]);
         rdt(`SDSW_OFS_STATUS);
         chk("status read", rd & 32'hFFFFD03F, ROWS[r][7]);
      end
      wr(`SDSW_OFS_STATUS, 32'hFFFFFFFF);
      rdt(`SDSW_OFS_STATUS);
      chk("status write ignored", rd & 32'hFFFFD03F, ROWS[3][7]);
      $display("test comparators done");
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_sys);
         mir <= 6'h01 << k;
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk("input mirror", 32'(axis_state_word[11:6]), 32'h1 << k);
      end
      $display("test mirrors done");
      for (int k = 0; k < 5; k++) begin
         @(posedge clk_sys);
         abs <= AB[k][2:0];
         @(posedge clk_sys);
         abs <= 3'h0;
         repeat (3) @(negedge clk_sys);
         chk("absolute flag", 32'(axis_state_word[13]), 32'(AB[k][3]));
      end
      $display("test absolute flag done");
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("reset clears", axis_state_word & 32'hFFFFF03F, 32'h00000000);
      @(posedge clk_sys);
      sys_rst <= 1'b0;
      $display("test reset done");
      test_done();
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      test_done();
   end
endmodule // sdsw_status_tb_top
